/* File: design/aux_pin_defs.svh */
// Offsets, field positions and reset values of the auxiliary pin port
`ifndef AUX_PIN_DEFS_SVH
`define AUX_PIN_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define AUX_CFG12_IDX    10'h059
`define AUX_CFG34_IDX    10'h05A
`define AUX_STATUS_IDX   10'h060
`define AUX_IRQ_STAT_IDX 10'h061
`define AUX_IRQ_CLR_IDX  10'h062
`define AUX_IRQ_EN_IDX   10'h063

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define AUX_NUM_PINS     3
`define AUX_DIR_BIT      0
`define AUX_CFG_RST      8'h00
`define AUX_CFG3_RST     4'h0
`define AUX_IRQ_RST      3'h0
`define AUX_SUSP_MASK12  8'hEE
`define AUX_SUSP_MASK34  4'hE

`endif

/* File: design/aux_pin_pkg.sv */
// Types shared by the auxiliary pin port
package aux_pin_pkg;

  // One pin's four-field settings nibble, bit 3 first
  typedef struct packed {
    logic out_state;
    logic sens;
    logic pol;
    logic dir;
  } pin_cfg_s;

endpackage : aux_pin_pkg

/* File: design/aux_pin_config_port.sv */
// APB slave and pin logic of the auxiliary input/output pins
`timescale 1ns/10ps
`include "aux_pin_defs.svh"

module aux_pin_config_port
  import aux_pin_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_usb_suspend,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [2:0]  i_aux_in,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [2:0]  o_aux_out,
  output logic      [2:0]  o_aux_oe,
  output logic             o_irq
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic pin_true(input logic lvl, input logic pol);
    pin_true = (lvl == pol);
  endfunction : pin_true

  logic [7:0]  cfg12_r;
  logic [7:0]  cfg12_nxt;
  logic [3:0]  cfg34_r;
  logic [3:0]  cfg34_nxt;
  logic [2:0]  cap_r;
  logic [2:0]  cap_nxt;
  logic [2:0]  asserted_prev_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_stat_nxt;
  logic [2:0]  irq_en_r;
  logic [2:0]  asserted;
  logic [2:0]  state_bits;
  logic [2:0]  events;
  logic [31:0] rd_mux;
  pin_cfg_s    cfg [0:2];

  wire [9:0] word_addr    = i_paddr[11:2];
  wire       sel_cfg12    = (word_addr == `AUX_CFG12_IDX);
  wire       sel_cfg34    = (word_addr == `AUX_CFG34_IDX);
  wire       sel_status   = (word_addr == `AUX_STATUS_IDX);
  wire       sel_irq_stat = (word_addr == `AUX_IRQ_STAT_IDX);
  wire       sel_irq_clr  = (word_addr == `AUX_IRQ_CLR_IDX);
  wire       sel_irq_en   = (word_addr == `AUX_IRQ_EN_IDX);
  wire       mapped       = sel_cfg12 | sel_cfg34 | sel_status | sel_irq_stat | sel_irq_clr | sel_irq_en;

  // First access cycle fetches data; the following edge, with pready high, completes
  wire       access_first = i_psel & i_penable & ~o_pready;
  wire       xfer         = i_psel & i_penable & o_pready;
  wire       wr_cfg12     = xfer & i_pwrite & sel_cfg12;
  wire       wr_cfg34     = xfer & i_pwrite & sel_cfg34;
  wire       wr_irq_clr   = xfer & i_pwrite & sel_irq_clr;
  wire       wr_irq_en    = xfer & i_pwrite & sel_irq_en;
  // Clear of edge captures coincides with the data fetch so nothing slips between
  wire       rd_status    = access_first & ~i_pwrite & sel_status;

  assign cfg[0] = cfg12_r[3:0];
  assign cfg[1] = cfg12_r[7:4];
  assign cfg[2] = cfg34_r;

  // All checks of this block share the system clock and its reset
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // ****************************************************************
  // Per-pin input logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `AUX_NUM_PINS; gi++) begin : g_pin
      // Input decode is blanked on an output pin
      assign asserted[gi]   = pin_true(i_aux_in[gi], cfg[gi].pol) & ~cfg[gi].dir;
      // Set wins over the read clear
      assign cap_nxt[gi]    = (asserted[gi] & cfg[gi].sens) | (cap_r[gi] & ~rd_status);
      assign state_bits[gi] = ~cfg[gi].dir & (cfg[gi].sens ? cap_r[gi] : asserted[gi]);
      assign events[gi]     = asserted[gi] & ~asserted_prev_r[gi];

      a_level_state: assert property (!cfg[gi].dir && !cfg[gi].sens |-> state_bits[gi] == asserted[gi])
        else $error("level state bit does not follow input");
      a_edge_capture: assert property (asserted[gi] && cfg[gi].sens |=> cap_r[gi])
        else $error("edge assertion not captured");
      a_read_race: assert property (rd_status && asserted[gi] && cfg[gi].sens |=> cap_r[gi] ##1 cap_r[gi] || rd_status)
        else $error("capture lost on simultaneous read");
      a_output_quiet: assert property (cfg[gi].dir |-> !state_bits[gi] && !asserted[gi])
        else $error("output pin reports input state");
      a_drive_high: assert property (cfg[gi].dir && cfg[gi].out_state |=> o_aux_oe[gi] && o_aux_out[gi])
        else $error("output pin not driven high");
      a_drive_low: assert property (cfg[gi].dir && !cfg[gi].out_state |=> o_aux_oe[gi] && !o_aux_out[gi])
        else $error("output pin not driven low");
      a_input_release: assert property (!cfg[gi].dir |=> !o_aux_oe[gi] && !o_aux_out[gi])
        else $error("input pin driven");
      a_cap_hold: assert property (cap_r[gi] && !rd_status |=> cap_r[gi])
        else $error("edge capture dropped without a status read");
      a_level_no_cap: assert property (!cfg[gi].sens && !cap_r[gi] |=> !cap_r[gi])
        else $error("level mode pin captured an edge");
      a_event_sets: assert property (events[gi] |=> irq_stat_r[gi])
        else $error("pin event did not set interrupt status");
      a_stat_sticky: assert property (irq_stat_r[gi] && !wr_irq_clr |=> irq_stat_r[gi])
        else $error("interrupt status bit lost without a clear");
      a_clear_bit: assert property (wr_irq_clr && i_pwdata[gi] && !events[gi] |=> !irq_stat_r[gi])
        else $error("interrupt status bit not cleared");
      a_clear_keeps: assert property (wr_irq_clr && !i_pwdata[gi] && irq_stat_r[gi] |=> irq_stat_r[gi])
        else $error("clear write hit an unselected bit");
    end
  endgenerate

  // ****************************************************************
  // Next values
  // ****************************************************************
  // Suspend clears only the direction bits and wins over a simultaneous write
  assign cfg12_nxt = (wr_cfg12 ? i_pwdata[7:0] : cfg12_r) & (i_usb_suspend ? `AUX_SUSP_MASK12 : 8'hFF);
  assign cfg34_nxt = (wr_cfg34 ? i_pwdata[3:0] : cfg34_r) & (i_usb_suspend ? `AUX_SUSP_MASK34 : 4'hF);
  assign irq_stat_nxt = (irq_stat_r & ~(wr_irq_clr ? i_pwdata[2:0] : 3'h0)) | events;

  assign rd_mux = sel_cfg12    ? {24'h000000, cfg12_r}     :
                  sel_cfg34    ? {28'h0000000, cfg34_r}    :
                  sel_status   ? {29'h00000000, state_bits} :
                  sel_irq_stat ? {29'h00000000, irq_stat_r} :
                  sel_irq_en   ? {29'h00000000, irq_en_r}   : 32'h00000000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cfg12_r <= `AUX_CFG_RST;
      cfg34_r <= `AUX_CFG3_RST;
    end else begin
      cfg12_r <= cfg12_nxt;
      cfg34_r <= cfg34_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cap_r           <= `AUX_IRQ_RST;
      asserted_prev_r <= `AUX_IRQ_RST;
      irq_stat_r      <= `AUX_IRQ_RST;
      irq_en_r        <= `AUX_IRQ_RST;
      o_irq           <= 1'b0;
    end else begin
      cap_r           <= cap_nxt;
      asserted_prev_r <= asserted;
      irq_stat_r      <= irq_stat_nxt;
      irq_en_r        <= wr_irq_en ? i_pwdata[2:0] : irq_en_r;
      o_irq           <= |(irq_stat_nxt & (wr_irq_en ? i_pwdata[2:0] : irq_en_r));
    end
  end

  // Pin drive follows the stored settings one cycle later
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_aux_oe  <= 3'h0;
      o_aux_out <= 3'h0;
    end else begin
      o_aux_oe  <= {cfg[2].dir, cfg[1].dir, cfg[0].dir};
      o_aux_out <= {cfg[2].dir & cfg[2].out_state, cfg[1].dir & cfg[1].out_state,
                    cfg[0].dir & cfg[0].out_state};
    end
  end

  // One wait state on every transfer; unmapped words answer with an error
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= access_first;
      o_pslverr <= access_first & ~mapped;
      o_prdata  <= access_first ? rd_mux : o_prdata;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_cfg12_write;
    wr_cfg12 && !i_usb_suspend;
  endsequence

  sequence s_dir_applied;
    o_aux_oe[0] == $past(i_pwdata[0], 2);
  endsequence

  a_cfg12_store: assert property (s_cfg12_write |=> cfg12_r == $past(i_pwdata[7:0]))
    else $error("pin 1/2 settings not stored");
  a_cfg34_store: assert property (wr_cfg34 && !i_usb_suspend |=> cfg34_r == $past(i_pwdata[3:0]))
    else $error("pin 3 settings not stored");
  a_dir_to_pin: assert property (s_cfg12_write ##1 !wr_cfg12 && !i_usb_suspend |=> s_dir_applied)
    else $error("direction write did not reach pin 1");
  a_suspend_input: assert property (i_usb_suspend |=> cfg12_r[0] == 1'b0 && cfg12_r[4] == 1'b0 && cfg34_r[0] == 1'b0
                                    ##1 o_aux_oe == 3'h0 || $past(wr_cfg12 || wr_cfg34))
    else $error("suspend left a pin as output");
  a_read_clears: assert property (rd_status && !asserted[0] |=> !cap_r[0])
    else $error("status read did not clear capture");
  a_pready_pulse: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("pready not a single cycle");

  // ****************************************************************
  // Bus response checks
  // ****************************************************************
  // An unmapped word is answered, never left hanging, so software sees the error
  sequence s_err_answer;
    o_pready && o_pslverr ##1 !o_pready;
  endsequence

  sequence s_ok_answer;
    o_pready && !o_pslverr;
  endsequence

  a_err_unmapped: assert property (access_first && !mapped |=> s_err_answer)
    else $error("unmapped word answered without error");
  a_ok_mapped: assert property (access_first && mapped |=> s_ok_answer)
    else $error("mapped word answered with error");
  a_err_in_ready: assert property (o_pslverr |-> o_pready)
    else $error("error flag outside the ready cycle");
  a_idle_no_ready: assert property (!i_psel |=> !o_pready)
    else $error("ready raised without a selected transfer");

  // ****************************************************************
  // Read data checks
  // ****************************************************************
  // Read data is only refreshed at the fetch edge, so it stays put while software looks
  a_rdata_hold: assert property (!access_first |=> $stable(o_prdata))
    else $error("read data changed outside a fetch");
  a_rdata_cfg12: assert property (access_first && !i_pwrite && sel_cfg12 |=> o_prdata == {24'h000000, $past(cfg12_r)})
    else $error("pin 1/2 settings read back wrong");
  a_rdata_cfg34: assert property (access_first && !i_pwrite && sel_cfg34 |=> o_prdata == {28'h0000000, $past(cfg34_r)})
    else $error("pin 3 settings read back wrong");
  a_rdata_status: assert property (access_first && !i_pwrite && sel_status
                                   |=> o_prdata == {29'h00000000, $past(state_bits)})
    else $error("status read back wrong");
  a_rdata_clr_zero: assert property (access_first && sel_irq_clr |=> o_prdata == 32'h00000000)
    else $error("clear register did not read zero");
  a_rdata_unmapped: assert property (access_first && !mapped |=> o_prdata == 32'h00000000)
    else $error("unmapped word returned data");

  // ****************************************************************
  // Settings and interrupt checks
  // ****************************************************************
  // A refused write must leave every setting untouched
  a_unmapped_write: assert property (xfer && i_pwrite && !mapped && !i_usb_suspend
                                     |=> $stable(cfg12_r) && $stable(cfg34_r) && $stable(irq_en_r))
    else $error("unmapped write changed a setting");
  a_suspend_wins: assert property (i_usb_suspend && wr_cfg12 |=> !cfg12_r[0] && !cfg12_r[4])
    else $error("write beat suspend on a direction bit");
  a_suspend_keeps: assert property (i_usb_suspend && !wr_cfg12 |=> cfg12_r == ($past(cfg12_r) & `AUX_SUSP_MASK12))
    else $error("suspend disturbed fields other than direction");
  a_irq_level: assert property (o_irq == |(irq_stat_r & irq_en_r))
    else $error("interrupt line disagrees with enabled status");
  a_irq_en_store: assert property (wr_irq_en |=> irq_en_r == $past(i_pwdata[2:0]))
    else $error("interrupt enable not stored");

endmodule : aux_pin_config_port

/* File: test/aux_pin_load.sv */
// Model of the switches and loads on the auxiliary pins
`timescale 1ns/10ps
module aux_pin_load (
  input  wire logic [2:0] i_drive_level,
  input  wire logic [2:0] i_drive_en,
  input  wire logic [2:0] i_switch,
  output logic      [2:0] o_pin_level
);
  // A driven pin overrides the weak switch contact
  assign o_pin_level = (i_drive_en & i_drive_level) | (~i_drive_en & i_switch);
endmodule : aux_pin_load

/* File: test/tb_aux_pin_config_port.sv */
// Self-checking testbench of the auxiliary pin port
`timescale 1ns/10ps
module tb_aux_pin_config_port
  import aux_pin_pkg::*;
;
  localparam logic [11:0] CFG12 = 12'h164, CFG34 = 12'h168, STAT = 12'h180;
  localparam logic [11:0] ISTAT = 12'h184, ICLR = 12'h188, IEN = 12'h18C;
  logic        clk = 0, rst = 1, susp = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [2:0]  sw = '0, pin, aout, aoe;
  logic        pready, pslverr, irq;
  logic [33:0] q[$];
  int          n_errors = 0, num_checks = 0;

  aux_pin_config_port aux_pin_config_port_inst (.i_clk_sys(clk), .i_reset(rst), .i_usb_suspend(susp),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_aux_in(pin),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_aux_out(aout), .o_aux_oe(aoe), .o_irq(irq));
  aux_pin_load aux_pin_load_inst (.i_drive_level(aout), .i_drive_en(aoe), .i_switch(sw), .o_pin_level(pin));

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Expectation e: bit 33 marks a read, bit 32 the error flag, then the data
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [33:0] e);
    @(posedge clk);
    q.push_back(e);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    logic [33:0] e;
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) chk(prdata, e[31:0]);
    end
  end

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [11:0] cfg;
    logic [2:0]  st, eo, ev;
    pin_cfg_s    c;
    void'($urandom(52));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(CFG12, 0, 0, {2'b10, 32'h0});
    chk(aoe, 0);
    apb(CFG12, 1, 32'h99, 0);
    apb(CFG34, 1, 32'h01, 0);
    wt(3);
    chk({aoe, aout}, 6'h3B);
    apb(CFG12, 1, 32'h11, 0);
    apb(CFG34, 1, 32'h09, 0);
    wt(3);
    chk({aoe, aout}, 6'h3C);
    // Level mode only here, so the status bits follow the pins directly
    for (int k = 0; k < 8; k++) begin
      cfg = 12'($urandom) & 12'hBBB;
      sw <= 3'($urandom);
      apb(CFG12, 1, {24'h0, cfg[7:0]}, 0);
      apb(CFG34, 1, {24'h0, 4'hF, cfg[11:8]}, 0);
      wt(2);
      for (int i = 0; i < 3; i++) begin
        c = cfg[i*4 +: 4];
        st[i] = !c.dir && (sw[i] == c.pol);
        eo[i] = c.dir;
        ev[i] = c.dir & c.out_state;
      end
      apb(STAT, 0, 0, {2'b10, 29'h0, st});
      apb(CFG34, 0, 0, {2'b10, 28'h0, cfg[11:8]});
      chk({aoe, aout}, {eo, ev});
    end
    sw <= 3'h7;
    apb(CFG12, 1, 32'h44, 0);
    apb(CFG34, 1, 32'h04, 0);
    apb(STAT, 0, 0, {2'b10, 32'h0});
    sw <= 3'h6;
    wt(1);
    sw <= 3'h7;
    wt(2);
    apb(STAT, 0, 0, {2'b10, 32'h1});
    apb(STAT, 0, 0, {2'b10, 32'h0});
    // Input held asserted across a read: the fetch edge recaptures it
    sw <= 3'h6;
    wt(2);
    apb(STAT, 0, 0, {2'b10, 32'h1});
    sw <= 3'h7;
    apb(STAT, 0, 0, {2'b10, 32'h1});
    apb(STAT, 0, 0, {2'b10, 32'h0});
    apb(CFG12, 1, 32'h99, 0);
    susp <= 1'b1;
    wt(1);
    susp <= 1'b0;
    wt(2);
    chk(aoe, 0);
    apb(CFG12, 0, 0, {2'b10, 32'h88});
    sw <= 3'h0;
    apb(CFG12, 1, 32'h22, 0);
    apb(CFG34, 1, 32'h02, 0);
    apb(IEN, 1, 32'h7, 0);
    apb(ICLR, 1, 32'h7, 0);
    wt(2);
    chk(irq, 0);
    sw <= 3'h1;
    wt(3);
    chk(irq, 1);
    apb(ISTAT, 0, 0, {2'b10, 32'h1});
    apb(IEN, 1, 32'h0, 0);
    wt(2);
    chk(irq, 0);
    apb(IEN, 1, 32'h7, 0);
    apb(ICLR, 1, 32'h1, 0);
    wt(2);
    chk(irq, 0);
    apb(ICLR, 0, 0, {2'b10, 32'h0});
    apb(12'h000, 0, 0, {2'b11, 32'h0});
    apb(12'h004, 1, 32'hFF, {2'b01, 32'h0});
    wt(2);
    report_and_stop();
  end
endmodule : tb_aux_pin_config_port
